// File: bench/remote_controller_model.sv
// Remote controller model: takes response characters off the queue.
// Assumes the bench raises stall to hold reads off.
`timescale 1ns/1ns
module remote_controller_model (
    input  wire logic       sys_clk,
    input  wire logic       stall,
    input  wire logic       resp_valid,
    input  wire logic [7:0] resp_char,
    output logic            resp_ready
);
    string text = "";
    initial resp_ready = 1'b0;
    // Ready moves at the falling edge so the handshake never races the clock
    always @(negedge sys_clk) begin
        resp_ready <= !stall;
    end
    // Characters are collected in the order the queue offers them
    always @(posedge sys_clk) begin
        if (resp_valid === 1'b1 && resp_ready) begin
            text = {text, string'(resp_char)};
        end
    end
endmodule

// File: bench/tb_remote_status_queues.sv
// Self-checking bench of the remote status block with a controller model.
// Assumes small queues: 64 response characters, 4 error entries.
`timescale 1ns/1ns
module tb_remote_status_queues;
    import remote_status_pkg::*;
    logic sys_clk = 1'b0, rst_n = 1'b0, clear_status = 1'b0, cmd_valid = 1'b0;
    logic error_valid = 1'b0, stall = 1'b0;
    logic [15:0] condition_in = 16'h0000, cmd_value = 16'h0000, error_code = 16'h0000;
    cmd_t cmd_code = CMD_COND_Q;
    logic cmd_ready, resp_valid, resp_ready, msg_available, error_available, change_summary;
    logic [7:0] resp_char;
    int err_total = 0, samples_checked = 0, cycles = 0;
    string r;
    always #5 sys_clk = ~sys_clk;
    remote_status_queues #(.RESP_CHARS(64), .ERR_ENTRIES(4)) uut (
        .sys_clk(sys_clk), .rst_n(rst_n), .condition_in(condition_in),
        .clear_status(clear_status), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_value(cmd_value), .cmd_ready(cmd_ready), .error_valid(error_valid),
        .error_code(error_code), .resp_valid(resp_valid), .resp_char(resp_char),
        .resp_ready(resp_ready), .msg_available(msg_available),
        .error_available(error_available), .change_summary(change_summary));
    remote_controller_model ctl (.sys_clk(sys_clk), .stall(stall),
        .resp_valid(resp_valid), .resp_char(resp_char), .resp_ready(resp_ready));
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    // Decimal digits at the head of an answer
    function automatic int num(string s);
        int v = 0;
        for (int i = 0; i < s.len() && s[i] >= "0" && s[i] <= "9"; i++) begin
            v = v * 10 + (s[i] - "0");
        end
        return v;
    endfunction
    // Command is held until cmd_ready has been high at a rising edge
    task automatic send(input cmd_t code, input logic [15:0] value);
        @(negedge sys_clk);
        while (cmd_ready !== 1'b1) @(negedge sys_clk);
        cmd_valid = 1'b1;
        cmd_code = code;
        cmd_value = value;
        @(negedge sys_clk);
        cmd_valid = 1'b0;
    endtask
    // Query and collect the answer up to LF; hold keeps the controller stalled
    task automatic query(input cmd_t code, input logic [15:0] value, input bit hold);
        ctl.text = "";
        stall = hold;
        send(code, value);
        if (hold) begin
            repeat (40) @(negedge sys_clk);
            chk(msg_available, 1'b1);
            chk(ctl.text.len(), 0);
            stall = 1'b0;
        end
        for (int n = 0; n < 300 && (ctl.text.len() == 0
             || ctl.text[ctl.text.len()-1] != 8'h0A); n++) @(negedge sys_clk);
        r = ctl.text;
        @(negedge sys_clk);
        chk(msg_available, 1'b0);
        chk(resp_valid, 1'b0);
    endtask
    task automatic test_regs();
        condition_in = 16'h0004;
        repeat (3) @(negedge sys_clk);
        query(CMD_COND_Q, 16'h0000, 1'b1);
        chk(num(r), 4);
        chk(r.len(), 2);
        condition_in = 16'hFFFF;
        query(CMD_COND_Q, 16'h0000, 1'b0);
        chk(num(r), 65535);
        chk(r.len(), 6);
        query(CMD_CHG0_Q, 16'h0000, 1'b0);
        chk(num(r), 65531);
        query(CMD_CHG0_Q, 16'h0000, 1'b0);
        chk(r == "0\n", 1);
    endtask
    task automatic test_change();
        query(CMD_CHG1_Q, 16'h0000, 1'b0);
        condition_in = 16'hEFFF;
        repeat (4) @(negedge sys_clk);
        chk(change_summary, 1'b0);
        send(CMD_EN1_W, 16'h1000);
        repeat (3) @(negedge sys_clk);
        chk(change_summary, 1'b1);
        query(CMD_EN1_Q, 16'h0000, 1'b0);
        chk(num(r), 4096);
        query(CMD_CHG1_Q, 16'h0000, 1'b0);
        chk(num(r), 4096);
        chk(change_summary, 1'b0);
        query(CMD_CHG1_Q, 16'h0000, 1'b0);
        chk(r == "0\n", 1);
    endtask
    task automatic test_errors();
        int exp_q[5] = '{20, 30, 1, 1, 0};
        query(CMD_ERR_Q, 16'h0000, 1'b0);
        chk(num(r), 0);
        chk(error_available, 1'b0);
        error_valid = 1'b1;
        for (int i = 1; i <= 5; i++) begin
            error_code = 16'(i * 10);
            @(negedge sys_clk);
        end
        error_valid = 1'b0;
        chk(error_available, 1'b1);
        query(CMD_ERR_Q, 16'h0000, 1'b0);
        chk(num(r), 10);
        error_valid = 1'b1;
        error_code = 16'h003C;
        @(negedge sys_clk);
        error_valid = 1'b0;
        foreach (exp_q[i]) begin
            query(CMD_ERR_Q, 16'h0000, 1'b0);
            chk(num(r), exp_q[i]);
        end
        query(CMD_ERROR_EXPLANATION_QUERY_Q, 16'h0000, 1'b0);
        chk(r == "NO ERROR\n", 1);
        error_valid = 1'b1;
        @(negedge sys_clk);
        error_valid = 1'b0;
        chk(error_available, 1'b1);
        clear_status = 1'b1;
        @(negedge sys_clk);
        clear_status = 1'b0;
        @(negedge sys_clk);
        chk(error_available, 1'b0);
    endtask
    // Hang guard: the tests need well under 5000 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            test_done();
        end
    end
    initial begin
        repeat (8) @(negedge sys_clk);
        rst_n = 1'b1;
        test_regs();
        test_change();
        test_errors();
        test_done();
    end
endmodule

// File: hdl/change_latch_bank.sv
// One bank of change-latching bits with clear on read.
// Assumes the condition input is already registered in this clock domain.
`timescale 1ns/1ns
module change_latch_bank
    import remote_status_pkg::*;
#(
    parameter int WIDTH = REG_W
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] cond,
    input  wire logic             clear,
    output logic      [WIDTH-1:0] changed
);
    logic [WIDTH-1:0] prev_q;
    logic [WIDTH-1:0] changed_q;
    logic             primed_q;
    logic             warm_q;
    logic [WIDTH-1:0] edge_hit;

    if (WIDTH < 1) begin : g_bad
        $error("change_latch_bank needs WIDTH >= 1");
    end

    // No edge is seen until the first condition sample is held
    assign edge_hit = primed_q ? (cond ^ prev_q) : '0;

    // The upstream register still shows its reset value at the first edge,
    // so two edges pass before prev_q holds a real sample; no false change
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_q   <= '0;
            warm_q   <= 1'b0;
            primed_q <= 1'b0;
        end else begin
            prev_q   <= cond;
            warm_q   <= 1'b1;
            primed_q <= warm_q;
        end
    end

    // A change in the clearing cycle survives: set wins over clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            changed_q <= WIDTH'(CHANGE_RESET);
        end else begin
            changed_q <= (clear ? '0 : changed_q) | edge_hit;
        end
    end

    assign changed = changed_q;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    change_latches_a: assert property (##1 (changed_q & $past(edge_hit)) == $past(edge_hit))
        else $error("Change bit did not latch");
    change_read_clear_a: assert property (clear && edge_hit == '0 |=> changed_q == '0)
        else $error("Change bank not cleared after read");
endmodule

// File: hdl/remote_status_queues.sv
// Remote status registers, response queue and error queue.
// Assumes a parser hands over decoded commands; power-off is rst_n.
//
// Operation
// - Condition query returns present condition value
// - Query answers are decimal, bits 0 to 15
// - Reading a change bank clears it
// - Enable bits gate change bits into summary
// - Settled request needs bank 1 enable bit 12
// - Enable registers load and read back unchanged
// - Queries load response queue, 800 characters
// - Read characters leave the response queue
// - Empty response queue supplies no data
// - Message available while response queue nonempty
// - Reported errors append their code
// - Error query returns and removes oldest
// - Empty error queue answers code zero
// - Error available while error queue nonempty
// - Error queue cleared by power-off, clear status
// - Error queue holds 16 entries
// - Overflow keeps 15, last slot overflow code
// - After overflow drop errors until read
// - Explanation query returns text for code
`timescale 1ns/1ns
module remote_status_queues
    import remote_status_pkg::*;
#(
    parameter int          RESP_CHARS    = RESP_DEPTH,
    parameter int          ERR_ENTRIES   = ERRQ_DEPTH,
    parameter logic [15:0] OVFL_CODE     = 16'h0001,  // Arbitrary overflow code
    parameter logic [15:0] CMD_ERR_LAST  = 16'h00FF,  // Last command error code
    parameter logic [15:0] EXEC_ERR_LAST = 16'h01FF   // Last execution error code
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] condition_in,
    input  wire logic        clear_status,
    input  wire logic        cmd_valid,
    input  wire cmd_t        cmd_code,
    input  wire logic [15:0] cmd_value,
    output logic             cmd_ready,
    input  wire logic        error_valid,
    input  wire logic [15:0] error_code,
    output logic             resp_valid,
    output logic [7:0]       resp_char,
    input  wire logic        resp_ready,
    output logic             msg_available,
    output logic             error_available,
    output logic             change_summary
);
    localparam int RCW = $clog2(RESP_CHARS + 1);
    localparam int ECW = $clog2(ERR_ENTRIES + 1);

    if (ERR_ENTRIES < 2 || RESP_CHARS < 8) begin : g_bad
        $error("remote_status_queues needs deeper queues");
    end

    fmt_state_t     st_q;
    fmt_state_t     st_d;
    logic [15:0]    cond_q;
    logic [15:0]    en0_q;
    logic [15:0]    en1_q;
    logic [15:0]    chg0;
    logic [15:0]    chg1;
    logic [15:0]    num_q;
    logic [2:0]     pow_q;
    logic [3:0]     digit_q;
    logic           lead_q;
    logic           with_text_q;
    logic [127:0]   text_q;
    logic [3:0]     chr_q;
    logic           cmd_ready_q;
    logic           summary_q;
    logic           discard_q;
    logic           accept;
    logic           is_query;
    logic           rd_chg0;
    logic           rd_chg1;
    logic           push_valid;
    logic [7:0]     push_char;
    logic           push_ready;
    logic           advance;
    logic           num_ge;
    logic [RCW-1:0] resp_cnt;
    logic           err_in_valid;
    logic [15:0]    err_in_data;
    logic           err_avail;
    logic [15:0]    err_head;
    logic           err_pop;
    logic [ECW-1:0] err_cnt;

    // Explanation selected by the error code's range
    function automatic logic [127:0] text_for(input logic [15:0] code);
        if (code == 16'h0000) begin
            text_for = TXT_NONE;
        end else if (code == OVFL_CODE) begin
            text_for = TXT_OVFL;
        end else if (code <= CMD_ERR_LAST) begin
            text_for = TXT_CMD;
        end else if (code <= EXEC_ERR_LAST) begin
            text_for = TXT_EXEC;
        end else begin
            text_for = TXT_DEV;
        end
    endfunction

    assign accept   = cmd_valid && cmd_ready_q;
    assign is_query = cmd_code != CMD_EN0_W && cmd_code != CMD_EN1_W;
    assign rd_chg0  = accept && cmd_code == CMD_CHG0_Q;
    assign rd_chg1  = accept && cmd_code == CMD_CHG1_Q;
    assign err_pop  = accept && cmd_code == CMD_ERR_Q && err_avail;
    assign num_ge   = num_q >= pow10(pow_q);

    // Condition inputs sampled once so every reader sees one value
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cond_q <= 16'h0000;
        end else begin
            cond_q <= condition_in;
        end
    end

    change_latch_bank #(.WIDTH(REG_W)) u_bank0 (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .cond    (cond_q),
        .clear   (rd_chg0),
        .changed (chg0)
    );

    change_latch_bank #(.WIDTH(REG_W)) u_bank1 (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .cond    (cond_q),
        .clear   (rd_chg1),
        .changed (chg1)
    );

    // Enable registers written by command
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            en0_q <= ENABLE_RESET;
            en1_q <= ENABLE_RESET;
        end else if (accept && cmd_code == CMD_EN0_W) begin
            en0_q <= cmd_value;
        end else if (accept && cmd_code == CMD_EN1_W) begin
            en1_q <= cmd_value;
        end
    end

    // Summary feeds the status byte; bank 1 bit 12 covers settling
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            summary_q <= 1'b0;
        end else begin
            summary_q <= |(chg0 & en0_q) || |(chg1 & en1_q);
        end
    end

    // Character source for the response queue
    always_comb begin
        push_valid = 1'b0;
        push_char  = CHAR_LF;
        case (st_q)
            ST_NUM: begin
                push_valid = !num_ge && (digit_q != 4'h0 || lead_q ||
                                         pow_q == 3'(DIGITS - 1));
                push_char  = CHAR_ZERO + 8'(digit_q);
            end
            ST_COMMA: begin
                push_valid = 1'b1;
                push_char  = CHAR_COMMA;
            end
            ST_TEXT: begin
                push_char  = text_q[chr_q*8 +: 8];
                push_valid = push_char != 8'h00;
            end
            ST_TERM: begin
                push_valid = 1'b1;
            end
            default: begin
                push_valid = 1'b0;
            end
        endcase
    end

    // A full response queue stalls the formatter, never drops characters
    assign advance = !push_valid || push_ready;

    // Formatter state sequence
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                if (accept && cmd_code == CMD_ERROR_EXPLANATION_QUERY_Q) begin
                    st_d = ST_TEXT;
                end else if (accept && is_query) begin
                    st_d = ST_NUM;
                end
            end
            ST_NUM: begin
                if (advance && !num_ge && pow_q == 3'(DIGITS - 1)) begin
                    st_d = with_text_q ? ST_COMMA : ST_TERM;
                end
            end
            ST_COMMA: begin
                if (advance) begin
                    st_d = ST_TEXT;
                end
            end
            ST_TEXT: begin
                if (advance && chr_q == 4'h0) begin
                    st_d = ST_TERM;
                end
            end
            ST_TERM: begin
                if (advance) begin
                    st_d = ST_IDLE;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    // New commands only while the formatter is idle next cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q        <= ST_IDLE;
            cmd_ready_q <= 1'b0;
        end else begin
            st_q        <= st_d;
            cmd_ready_q <= st_d == ST_IDLE;
        end
    end

    // Snapshot of the answer and digit extraction by subtraction
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            num_q       <= 16'h0000;
            pow_q       <= 3'h0;
            digit_q     <= 4'h0;
            lead_q      <= 1'b0;
            with_text_q <= 1'b0;
            text_q      <= '0;
        end else if (st_q == ST_IDLE && accept) begin
            pow_q       <= 3'h0;
            digit_q     <= 4'h0;
            lead_q      <= 1'b0;
            with_text_q <= cmd_code == CMD_ERR_Q;
            text_q      <= text_for(cmd_value);
            case (cmd_code)
                CMD_COND_Q: num_q <= cond_q;
                CMD_CHG0_Q: num_q <= chg0;
                CMD_CHG1_Q: num_q <= chg1;
                CMD_EN0_Q:  num_q <= en0_q;
                CMD_EN1_Q:  num_q <= en1_q;
                CMD_ERR_Q: begin
                    num_q  <= err_avail ? err_head : 16'h0000;
                    text_q <= text_for(err_avail ? err_head : 16'h0000);
                end
                default:    num_q <= num_q;
            endcase
        end else if (st_q == ST_NUM && advance) begin
            if (num_ge) begin
                num_q   <= num_q - pow10(pow_q);
                digit_q <= digit_q + 4'h1;
            end else begin
                lead_q  <= lead_q || push_valid;
                digit_q <= 4'h0;
                pow_q   <= pow_q + 3'h1;
            end
        end
    end

    // Text pointer walks from the leftmost character
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            chr_q <= 4'hF;
        end else if (st_q == ST_IDLE) begin
            chr_q <= 4'(TEXT_CHARS - 1);
        end else if (st_q == ST_TEXT && advance) begin
            chr_q <= chr_q - 4'h1;
        end
    end

    // Response queue; reads by the controller pop characters
    sync_fifo #(.WIDTH(CHAR_W), .DEPTH(RESP_CHARS)) u_resp_q (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .flush     (1'b0),
        .in_valid  (push_valid),
        .in_data   (push_char),
        .in_ready  (push_ready),
        .out_valid (resp_valid),
        .out_data  (resp_char),
        .out_ready (resp_ready),
        .count     (resp_cnt)
    );

    // The last free slot is reserved for the overflow marker
    assign err_in_valid = error_valid && !discard_q && !clear_status;
    assign err_in_data  = (err_cnt == ECW'(ERR_ENTRIES - 1)) ? OVFL_CODE : error_code;

    // Drop mode ends on the first read or on clear status
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            discard_q <= 1'b0;
        end else if (clear_status) begin
            discard_q <= 1'b0;
        end else if (err_in_valid && err_cnt == ECW'(ERR_ENTRIES - 1)) begin
            discard_q <= 1'b1;
        end else if (err_pop) begin
            discard_q <= 1'b0;
        end
    end

    // Error queue; flushed on clear status, reset covers power-off
    sync_fifo #(.WIDTH(REG_W), .DEPTH(ERR_ENTRIES)) u_err_q (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .flush     (clear_status),
        .in_valid  (err_in_valid),
        .in_data   (err_in_data),
        .in_ready  (),
        .out_valid (err_avail),
        .out_data  (err_head),
        .out_ready (err_pop),
        .count     (err_cnt)
    );

    assign cmd_ready       = cmd_ready_q;
    assign msg_available   = resp_valid;
    assign error_available = err_avail;
    assign change_summary  = summary_q;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence query_taken_s;
        accept && is_query && resp_cnt < RCW'(RESP_CHARS - 40);
    endsequence

    sequence line_end_s;
        ##[1:120] (push_valid && push_ready && push_char == CHAR_LF);
    endsequence

    query_loads_resp_a: assert property (query_taken_s |-> line_end_s)
        else $error("Query answer did not reach the response queue");
    enable_readback_a: assert property (accept && cmd_code == CMD_EN1_W |=> en1_q == $past(cmd_value))
        else $error("Enable register did not load");
    summary_gate_a: assert property (##1 summary_q == $past(|(chg0 & en0_q) || |(chg1 & en1_q)))
        else $error("Summary does not follow enabled changes");
    settled_gate_a: assert property (chg1[SETTLED_BIT] && !en1_q[SETTLED_BIT] && chg0 == '0
                                     && (chg1 & en1_q) == '0 |=> !summary_q)
        else $error("Settled change raised summary while disabled");
    err_zero_code_a: assert property (accept && cmd_code == CMD_ERR_Q && !err_avail
                                      |=> st_q == ST_NUM && num_q == 16'h0000)
        else $error("Empty error queue did not answer zero");
    err_pop_a: assert property (err_pop && !err_in_valid && !clear_status
                                |=> err_cnt == $past(err_cnt) - 1'b1)
        else $error("Error query did not remove an entry");
    overflow_slot_a: assert property (err_in_valid && err_cnt == ECW'(ERR_ENTRIES - 1)
                                      |-> err_in_data == OVFL_CODE ##1 discard_q)
        else $error("Overflow slot holds a plain error");
    discard_hold_a: assert property (discard_q && !err_pop |=> err_cnt <= $past(err_cnt))
        else $error("Error stored while discarding");
    cls_empties_a: assert property (clear_status |=> err_cnt == '0 && !error_available)
        else $error("Clear status left errors queued");
endmodule

// File: hdl/sync_fifo.sv
// Synchronous FIFO with valid/ready on both sides and a flush.
// Assumes one clock; flush drops all content in one cycle.
`timescale 1ns/1ns
module sync_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic                           sys_clk,
    input  wire logic                           rst_n,
    input  wire logic                           flush,
    input  wire logic                           in_valid,
    input  wire logic [WIDTH-1:0]               in_data,
    output logic                                in_ready,
    output logic                                out_valid,
    output logic [WIDTH-1:0]                    out_data,
    input  wire logic                           out_ready,
    output logic [$clog2(DEPTH+1)-1:0]          count
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    if (DEPTH < 2 || WIDTH < 1) begin : g_bad
        $error("sync_fifo needs DEPTH >= 2 and WIDTH >= 1");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [CW-1:0]    count_q;
    logic [CW-1:0]    count_d;
    logic             in_ready_q;
    logic             out_valid_q;
    logic             push;
    logic             pop;

    assign push    = in_valid && in_ready_q && !flush;
    assign pop     = out_ready && out_valid_q && !flush;
    assign count_d = flush ? '0 : count_q + CW'(push) - CW'(pop);

    // Storage has no reset; only pointers define what is valid
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data;
        end
    end

    // Pointers wrap at the last slot since DEPTH need not be a power of two
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else if (flush) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
            end
        end
    end

    // Flags are registered from the next count so they need no decode
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q     <= '0;
            in_ready_q  <= 1'b1;
            out_valid_q <= 1'b0;
        end else begin
            count_q     <= count_d;
            in_ready_q  <= count_d != CW'(DEPTH);
            out_valid_q <= count_d != '0;
        end
    end

    assign in_ready  = in_ready_q;
    assign out_valid = out_valid_q;
    assign out_data  = mem[rd_ptr_q];
    assign count     = count_q;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    fifo_avail_flag_a: assert property (out_valid_q == (wr_ptr_q != rd_ptr_q || !in_ready_q))
        else $error("FIFO valid flag disagrees with its count");
    fifo_empty_hold_a: assert property (!out_valid_q && !flush |=> count_q >= $past(count_q))
        else $error("Empty FIFO lost a word");
endmodule

// File: include/remote_status_pkg.sv
// Shared constants and types of the remote status block.
// Assumes a single 100 MHz clock domain and an upstream command parser.
package remote_status_pkg;
    localparam int REG_W       = 16;     // Width of every status register
    localparam int CHAR_W      = 8;      // Width of one response character
    localparam int RESP_DEPTH  = 800;    // Response queue capacity in characters
    localparam int ERRQ_DEPTH  = 16;     // Error queue capacity in entries
    localparam int SETTLED_BIT = 12;     // Output settled bit of bank 1
    localparam int DIGITS      = 5;      // Decimal digits of a 16-bit value
    localparam int TEXT_CHARS  = 16;     // Characters of one explanation

    localparam logic [15:0] ENABLE_RESET = 16'h0000;
    localparam logic [15:0] CHANGE_RESET = 16'h0000;
    localparam logic [7:0]  CHAR_ZERO    = 8'h30;
    localparam logic [7:0]  CHAR_COMMA   = 8'h2C;
    localparam logic [7:0]  CHAR_LF      = 8'h0A;

    // Explanation texts, right-aligned, leading null bytes are skipped
    localparam logic [127:0] TXT_NONE  = "NO ERROR";
    localparam logic [127:0] TXT_OVFL  = "QUEUE OVERFLOW";
    localparam logic [127:0] TXT_CMD   = "COMMAND ERROR";
    localparam logic [127:0] TXT_EXEC  = "EXECUTION ERROR";
    localparam logic [127:0] TXT_DEV   = "DEVICE ERROR";

    typedef enum logic [3:0] {
        CMD_COND_Q    = 4'h0,
        CMD_CHG0_Q    = 4'h1,
        CMD_CHG1_Q    = 4'h2,
        CMD_EN0_Q     = 4'h3,
        CMD_EN1_Q     = 4'h4,
        CMD_EN0_W     = 4'h5,
        CMD_EN1_W     = 4'h6,
        CMD_ERR_Q     = 4'h7,
        CMD_ERROR_EXPLANATION_QUERY_Q = 4'h8
    } cmd_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_NUM   = 3'b001,
        ST_COMMA = 3'b011,
        ST_TEXT  = 3'b010,
        ST_TERM  = 3'b110
    } fmt_state_t;

    function automatic logic [15:0] pow10(input logic [2:0] idx);
        case (idx)
            3'h0:    pow10 = 16'h2710;
            3'h1:    pow10 = 16'h03E8;
            3'h2:    pow10 = 16'h0064;
            3'h3:    pow10 = 16'h000A;
            default: pow10 = 16'h0001;
        endcase
    endfunction
endpackage
